// ---- verilog/ddsoc_top.sv ----
// dds output control bits: control word capture, accumulator path and output pin select
// Notes on behaviour
// - reset field one holds accumulator path at zero, output at midscale.
// - clock-sleep one stops accumulation, output holds its value.
// - clock-sleep zero keeps the accumulator path clocked.
// - dac-sleep one powers the dac down.
// - dac-sleep zero keeps the dac powered.
// - bit-output enable one drives pin with msb or msb divided by two.
// - bit-output enable zero holds pin low, signal on dac only; wave select picks sine or ramp.
// - bit-output enable and divide select one pass msb directly.
// - bit-output enable with divide select zero outputs msb halved in frequency.
// - wave select one bypasses sine table, ramp output.
// - wave select zero feeds phase through the sine table.
// - word with top two bits zero is a control word write.
// - output signal appears seven cycles after reset field clears.
// - reset field clears only accumulator path, not frequency, phase, control.
// - writes accepted during clock sleep, seen after clocking resumes.
`timescale 1ns/1ps
`include "ddsoc_defs.svh"
module ddsoc_top
  import ddsoc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  input  wire logic                                 ce,
  // complete 16-bit words from the serial front end
  input  ddsoc_pkg::ddsoc_word_s                    word_in,
  // pin and analog side
  output logic                                      output_pin,
  output logic [9:0]                                dac_code,
  output logic                                      dac_power_down,
  // status
  output ddsoc_pkg::ddsoc_ctrl_s                    ctrl_out,
  output logic                                      accum_in_reset
);
  import ddsoc_pkg::*;

  ddsoc_ctrl_s            ctrl_r, ctrl_nxt;
  logic [27:0]            freq0_r, freq0_nxt, freq1_r, freq1_nxt;
  logic [11:0]            ph0_r, ph0_nxt, ph1_r, ph1_nxt;
  logic                   b28_r, b28_nxt, hlb_r, hlb_nxt, fsel_r, fsel_nxt, psel_r, psel_nxt;
  logic                   lsb_pend_r, lsb_pend_nxt;
  logic [13:0]            lsb_hold_r, lsb_hold_nxt;
  logic [27:0]            acc_r, acc_nxt;
  logic [11:0]            phs_r, phs_nxt;
  logic [2:0]             lat_r, lat_nxt;
  logic                   ramp_r, ramp_nxt, live_r, live_nxt;
  logic [9:0]             lut_q, dac_nxt;
  logic                   msb_r, msb_nxt, half_r, half_nxt, pin_nxt;
  logic [1:0]             addr;
  logic [15:0]            w;
  ddsoc_src_e             src;
  logic                   run;

  assign w    = word_in.data;
  assign addr = w[`DDSOC_ADDR_HI:`DDSOC_ADDR_LO];

  // register file: only whole words arrive here, so no field sees a half-shifted value
  always_comb begin
    ctrl_nxt     = ctrl_r;
    freq0_nxt    = freq0_r;
    freq1_nxt    = freq1_r;
    ph0_nxt      = ph0_r;
    ph1_nxt      = ph1_r;
    b28_nxt      = b28_r;
    hlb_nxt      = hlb_r;
    fsel_nxt     = fsel_r;
    psel_nxt     = psel_r;
    lsb_pend_nxt = lsb_pend_r;
    lsb_hold_nxt = lsb_hold_r;
    if (word_in.valid) begin
      case (addr)
        `DDSOC_ADDR_CTRL: begin
          b28_nxt                    = w[`DDSOC_BIT_B28];
          hlb_nxt                    = w[`DDSOC_BIT_HLB];
          fsel_nxt                   = w[`DDSOC_BIT_FSEL];
          psel_nxt                   = w[`DDSOC_BIT_PSEL];
          ctrl_nxt.accum_reset       = w[`DDSOC_BIT_RESET];
          ctrl_nxt.clock_sleep       = w[`DDSOC_BIT_CLK_SLEEP];
          ctrl_nxt.dac_sleep         = w[`DDSOC_BIT_DAC_SLEEP];
          ctrl_nxt.bit_output_enable = w[`DDSOC_BIT_OPBIT_EN];
          ctrl_nxt.msb_divide_select = w[`DDSOC_BIT_DIV_SEL];
          ctrl_nxt.wave_select       = w[`DDSOC_BIT_WAVE_SEL];
          lsb_pend_nxt               = 1'b0;
        end
        `DDSOC_ADDR_FREQ0, `DDSOC_ADDR_FREQ1: begin
          if (b28_r && !lsb_pend_r) begin
            lsb_pend_nxt = 1'b1;
            lsb_hold_nxt = w[13:0];
          end else if (b28_r) begin
            lsb_pend_nxt = 1'b0;
            if (addr == `DDSOC_ADDR_FREQ0) freq0_nxt = {w[13:0], lsb_hold_r};
            else freq1_nxt = {w[13:0], lsb_hold_r};
          end else if (addr == `DDSOC_ADDR_FREQ0) begin
            freq0_nxt = hlb_r ? {w[13:0], freq0_r[13:0]} : {freq0_r[27:14], w[13:0]};
          end else begin
            freq1_nxt = hlb_r ? {w[13:0], freq1_r[13:0]} : {freq1_r[27:14], w[13:0]};
          end
        end
        `DDSOC_ADDR_PHASE: begin
          if (w[13]) ph1_nxt = w[11:0];
          else ph0_nxt = w[11:0];
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
  end

  // control registers come out of reset with the accumulator reset field set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r     <= '0;
      ctrl_r.accum_reset <= `DDSOC_CTRL_RST_VAL;
      freq0_r    <= '0;
      freq1_r    <= '0;
      ph0_r      <= '0;
      ph1_r      <= '0;
      b28_r      <= 1'b0;
      hlb_r      <= 1'b0;
      fsel_r     <= 1'b0;
      psel_r     <= 1'b0;
      lsb_pend_r <= 1'b0;
      lsb_hold_r <= '0;
    end else if (ce) begin
      ctrl_r     <= ctrl_nxt;
      freq0_r    <= freq0_nxt;
      freq1_r    <= freq1_nxt;
      ph0_r      <= ph0_nxt;
      ph1_r      <= ph1_nxt;
      b28_r      <= b28_nxt;
      hlb_r      <= hlb_nxt;
      fsel_r     <= fsel_nxt;
      psel_r     <= psel_nxt;
      lsb_pend_r <= lsb_pend_nxt;
      lsb_hold_r <= lsb_hold_nxt;
    end
  end

  // internal clock gate modelled as an enable; register writes above stay live during sleep
  assign run = !ctrl_r.clock_sleep;

  // accumulator path: reset clears only this state, never the registers above
  always_comb begin
    acc_nxt  = acc_r;
    phs_nxt  = phs_r;
    ramp_nxt = ramp_r;
    lat_nxt  = lat_r;
    live_nxt = live_r;
    if (ctrl_r.accum_reset) begin
      acc_nxt  = '0;
      phs_nxt  = '0;
      ramp_nxt = 1'b0;
      lat_nxt  = '0;
      live_nxt = 1'b0;
    end else if (run) begin
      acc_nxt  = acc_r + (fsel_r ? freq1_r : freq0_r);
      phs_nxt  = acc_r[27:16] + (psel_r ? ph1_r : ph0_r);
      ramp_nxt = ctrl_r.wave_select;
      // output released a fixed seven cycles after reset clears
      if (lat_r != 3'(`DDSOC_RESET_LAT - 1)) lat_nxt = lat_r + 3'h1;
      live_nxt = (lat_r == 3'(`DDSOC_RESET_LAT - 1));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc_r  <= '0;
      phs_r  <= '0;
      ramp_r <= 1'b0;
      lat_r  <= '0;
      live_r <= 1'b0;
    end else if (ce) begin
      acc_r  <= acc_nxt;
      phs_r  <= phs_nxt;
      ramp_r <= ramp_nxt;
      lat_r  <= lat_nxt;
      live_r <= live_nxt;
    end
  end

  ddsoc_sine_lut u_lut (
    .sys_clk (sys_clk),
    .ce      (ce && run),
    .addr    (phs_r[11:4]),
    .data    (lut_q)
  );

  // output selection; a ramp bypasses the table, a sine uses it
  always_comb begin
    if (ctrl_r.bit_output_enable) begin
      src = ctrl_r.msb_divide_select ? DDSOC_SRC_MSB : DDSOC_SRC_MSB_HALF;
    end else begin
      src = ramp_r ? DDSOC_SRC_RAMP : DDSOC_SRC_SINE;
    end
    dac_nxt  = dac_code;
    msb_nxt  = msb_r;
    half_nxt = half_r;
    pin_nxt  = output_pin;
    if (!live_r) begin
      dac_nxt  = `DDSOC_MIDSCALE;
      msb_nxt  = 1'b0;
      half_nxt = 1'b0;
      pin_nxt  = 1'b0;
    end else if (run) begin
      dac_nxt = ramp_r ? phs_r[11:2] : lut_q;
      msb_nxt = dac_nxt[9];
      if (msb_nxt && !msb_r) half_nxt = !half_r;
      case (src)
        DDSOC_SRC_MSB:      pin_nxt = msb_nxt;
        DDSOC_SRC_MSB_HALF: pin_nxt = half_nxt;
        default:            pin_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dac_code       <= `DDSOC_MIDSCALE;
      msb_r          <= 1'b0;
      half_r         <= 1'b0;
      output_pin     <= 1'b0;
      dac_power_down <= 1'b0;
      ctrl_out       <= '0;
      accum_in_reset <= 1'b1;
    end else if (ce) begin
      dac_code       <= dac_nxt;
      msb_r          <= msb_nxt;
      half_r         <= half_nxt;
      output_pin     <= pin_nxt;
      dac_power_down <= ctrl_r.dac_sleep;
      ctrl_out       <= ctrl_r;
      accum_in_reset <= ctrl_r.accum_reset;
    end
  end

  // checks
  property p_ctrl_write;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && word_in.valid && addr == `DDSOC_ADDR_CTRL) |=> ctrl_r.accum_reset == $past(w[`DDSOC_BIT_RESET]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control word not captured");

  property p_no_ctrl_other;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && word_in.valid && addr != `DDSOC_ADDR_CTRL) |=> $stable(ctrl_r);
  endproperty
  a_no_ctrl_other: assert property (p_no_ctrl_other) else $error("non-control word changed control");

  property p_reset_mid;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && ctrl_r.accum_reset) |=> ##1 (dac_code == `DDSOC_MIDSCALE || !$past(ce));
  endproperty
  a_reset_mid: assert property (p_reset_mid) else $error("output not midscale in reset");

  property p_sleep_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && ctrl_r.clock_sleep && !ctrl_r.accum_reset && live_r) |=> $stable(acc_r);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("accumulator moved in sleep");

  property p_run_acc;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && run && !ctrl_r.accum_reset) |=> acc_r == $past(acc_r) + $past(fsel_r ? freq1_r : freq0_r);
  endproperty
  a_run_acc: assert property (p_run_acc) else $error("accumulator not advancing");

  property p_pd;
    @(posedge sys_clk) disable iff (!nrst)
    ce |=> dac_power_down == $past(ctrl_r.dac_sleep);
  endproperty
  a_pd: assert property (p_pd) else $error("dac power-down mismatch");

  property p_latency;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && ctrl_r.accum_reset) ##1 (ce && !ctrl_r.accum_reset && run)[*7] |=> live_r;
  endproperty
  a_latency: assert property (p_latency) else $error("output not live after seven cycles");

  property p_keep_freq;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && ctrl_r.accum_reset && !word_in.valid) |=> $stable(freq0_r) && $stable(freq1_r);
  endproperty
  a_keep_freq: assert property (p_keep_freq) else $error("reset touched frequency");

  property p_msb_pass;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && live_r && run && ctrl_r.bit_output_enable && ctrl_r.msb_divide_select) |=> output_pin == dac_code[9];
  endproperty
  a_msb_pass: assert property (p_msb_pass) else $error("msb not passed to pin");

  property p_msb_half;
    @(posedge sys_clk) disable iff (!nrst)
    (ce && live_r && run && ctrl_r.bit_output_enable && !ctrl_r.msb_divide_select) |=> output_pin == half_r;
  endproperty
  a_msb_half: assert property (p_msb_half) else $error("halved msb not on pin");
endmodule

// ---- verilog/ddsoc_defs.svh ----
// offsets, field positions, reset values and timing counts of the dds output control block
`ifndef DDSOC_DEFS_SVH
`define DDSOC_DEFS_SVH
`define DDSOC_WORD_W        16
`define DDSOC_ADDR_HI       15
`define DDSOC_ADDR_LO       14
`define DDSOC_ADDR_CTRL     2'h0
`define DDSOC_ADDR_FREQ0    2'h1
`define DDSOC_ADDR_FREQ1    2'h2
`define DDSOC_ADDR_PHASE    2'h3
`define DDSOC_BIT_B28       13
`define DDSOC_BIT_HLB       12
`define DDSOC_BIT_FSEL      11
`define DDSOC_BIT_PSEL      10
`define DDSOC_BIT_RESET     8
`define DDSOC_BIT_CLK_SLEEP 7
`define DDSOC_BIT_DAC_SLEEP 6
`define DDSOC_BIT_OPBIT_EN  5
`define DDSOC_BIT_DIV_SEL   3
`define DDSOC_BIT_WAVE_SEL  1
`define DDSOC_FREQ_W        28
`define DDSOC_PHASE_W       12
`define DDSOC_DAC_W         10
`define DDSOC_LUT_AW        8
`define DDSOC_RESET_LAT     7
`define DDSOC_CTRL_RST_VAL  1'b1
`define DDSOC_MIDSCALE      10'h200
`endif

// ---- verilog/ddsoc_pkg.sv ----
// types shared by the dds output control block
package ddsoc_pkg;
  `include "ddsoc_defs.svh"
  typedef struct packed {
    logic accum_reset;
    logic clock_sleep;
    logic dac_sleep;
    logic bit_output_enable;
    logic msb_divide_select;
    logic wave_select;
  } ddsoc_ctrl_s;
  typedef struct packed {
    logic [`DDSOC_WORD_W-1:0] data;
    logic                     valid;
  } ddsoc_word_s;
  typedef enum logic [1:0] {DDSOC_SRC_SINE, DDSOC_SRC_RAMP, DDSOC_SRC_MSB, DDSOC_SRC_MSB_HALF} ddsoc_src_e;
endpackage

// ---- verilog/ddsoc_sine_lut.sv ----
// quarter-free sine lookup table, registered read data
`timescale 1ns/1ps
module ddsoc_sine_lut (
  // clock and enable
  input  wire logic       sys_clk,
  input  wire logic       ce,
  // read port
  input  wire logic [7:0] addr,
  output logic      [9:0] data
);
  logic [9:0] rom [0:255];
  // table built at elaboration by a parabolic sine approximation, no file read
  genvar i;
  generate
    for (i = 0; i < 256; i++) begin : g_rom
      localparam int X = (i < 128) ? i : i - 128;
      localparam int A = (X * (128 - X) * 511) / 4096;
      assign rom[i] = (i < 128) ? 10'(512 + A) : 10'(511 - A);
    end
  endgenerate
  // read data registered
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      data <= rom[addr];
    end
  end
endmodule

// ---- verif/ddsoc_host_model.sv ----
// host controller model: hands whole 16-bit words to the word port
`timescale 1ns/1ps
module ddsoc_host_model (
  // clock
  input  wire logic              sys_clk,
  // word port towards the block
  output ddsoc_pkg::ddsoc_word_s word_o
);
  import ddsoc_pkg::*;

  // quiet line at time zero
  initial word_o = '0;

  // one word per call, valid for exactly one edge
  // the idle data line shows the inverse, so stale bits never pass for a fresh word
  task automatic send(input logic [15:0] w);
    logic [15:0] v;
    v = w;
    if (v[15:14] == 2'h0) begin
      v[4] = 1'b0;
      v[2] = 1'b0;
      v[0] = 1'b0;
      if (v[5]) v[1] = 1'b0;
    end
    @(posedge sys_clk);
    word_o <= '{data: v, valid: 1'b1};
    @(posedge sys_clk);
    word_o <= '{data: ~v, valid: 1'b0};
  endtask
endmodule

// ---- verif/ddsoc_top_test.sv ----
// self-checking bench for the dds output control block
`timescale 1ns/1ps
`include "ddsoc_defs.svh"
module ddsoc_top_test;
  import ddsoc_pkg::*;
  // design connections
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        ce      = 1'b1;
  ddsoc_word_s word_in;
  logic        output_pin;
  logic [9:0]  dac_code;
  logic        dac_power_down;
  ddsoc_ctrl_s ctrl_out;
  logic        accum_in_reset;
  // bookkeeping
  int          n_fail      = 0;
  int          comparisons = 0;
  int          rises;
  int          odd;
  logic [9:0]  prev;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  ddsoc_host_model host_u (.sys_clk(sys_clk), .word_o(word_in));

  ddsoc_top dut_u (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .ce             (ce),
    .word_in        (word_in),
    .output_pin     (output_pin),
    .dac_code       (dac_code),
    .dac_power_down (dac_power_down),
    .ctrl_out       (ctrl_out),
    .accum_in_reset (accum_in_reset)
  );

  // settle just after the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // v = {reset, clock sleep, dac sleep, bit output, divide select, wave select}
  function automatic logic [15:0] ctl(input logic [5:0] v);
    ctl = 16'h2000;  // frequency halves always pair
    ctl[`DDSOC_BIT_RESET] = v[5];
    ctl[`DDSOC_BIT_CLK_SLEEP] = v[4];
    ctl[`DDSOC_BIT_DAC_SLEEP] = v[3];
    ctl[`DDSOC_BIT_OPBIT_EN] = v[2];
    ctl[`DDSOC_BIT_DIV_SEL] = v[1];
    ctl[`DDSOC_BIT_WAVE_SEL] = v[0];
  endfunction

  // control write, then wait until ctrl_out has caught up
  task automatic wr(input logic [5:0] v);
    host_u.send(ctl(v));
    cyc(3);
  endtask

  // consecutive dac code steps against a fixed increment
  task automatic steps(input logic [9:0] d, input int n);
    logic [9:0] dd;
    odd = 0;
    repeat (n) begin
      prev = dac_code;
      cyc(1);
      dd = dac_code - prev;
      if (dd !== d) odd++;
    end
  endtask

  task automatic count_rises(input int n);
    logic last;
    rises = 0;
    last = output_pin;
    repeat (n) begin
      cyc(1);
      if (output_pin === 1'b1 && last !== 1'b1) rises++;
      last = output_pin;
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short; the tests need about 1500 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    summarize();
  end

  initial begin
    cyc(5);
    chk("reset dac_code", 16'h0200, dac_code);
    chk("reset pin", 16'h0000, output_pin);
    chk("reset ctrl_out", 16'h0000, ctrl_out);
    chk("reset accum", 16'h0001, accum_in_reset);
    @(posedge sys_clk) nrst <= 1'b1;
    cyc(2);
    chk("reset field", 16'h0001, ctrl_out.accum_reset);
    // frequency halves must pair before the first frequency write, else 0x100 lands in the low half
    wr(6'h20);
    host_u.send(16'h4000);
    host_u.send(16'h4100);
    // reset held plus one further field each pass; outputs stay at midscale
    for (int i = 0; i < 5; i++) begin
      wr(6'h20 | (6'h01 << i));
      chk("ctrl_out fields", 16'h0020 | (16'h0001 << i), ctrl_out);
      chk("dac power down", (i == 3), dac_power_down);
      chk("midscale in reset", 16'h0200, dac_code);
    end
    host_u.send(16'hc000);
    cyc(3);
    chk("phase word leaves ctrl", 16'h0030, ctrl_out);
    wr(6'h21);
    chk("still midscale", 16'h0200, dac_code);
    // release reset in ramp mode; output waits seven running cycles
    wr(6'h01);
    chk("accum released", 16'h0000, accum_in_reset);
    chk("midscale before latency", 16'h0200, dac_code);
    cyc(12);
    steps(10'h010, 8);
    chk("ramp step 16", 16'h0000, odd);
    // sleep freezes the path; a frequency change written meanwhile shows after resume
    wr(6'h11);
    prev = dac_code;
    host_u.send(16'h4000);
    host_u.send(16'h4200);
    cyc(6);
    chk("frozen in sleep", prev, dac_code);
    wr(6'h01);
    cyc(10);
    steps(10'h020, 8);
    chk("ramp step 32 after sleep", 16'h0000, odd);
    // accumulator reset keeps the frequency register
    wr(6'h21);
    chk("midscale again", 16'h0200, dac_code);
    wr(6'h01);
    cyc(12);
    steps(10'h020, 8);
    chk("frequency kept", 16'h0000, odd);
    // clock enable low freezes all state
    @(posedge sys_clk) ce <= 1'b0;
    cyc(2);
    prev = dac_code;
    cyc(5);
    chk("ce low freezes", prev, dac_code);
    @(posedge sys_clk) ce <= 1'b1;
    // sine through the table is not a constant step, pin stays low while dac routed
    wr(6'h00);
    cyc(12);
    steps(10'h020, 16);
    chk("sine not ramp", 16'h0001, odd > 0);
    count_rises(256);
    chk("pin idle when dac routed", 16'h0000, rises);
    // msb on the pin, direct and halved; msb period is 32 cycles
    wr(6'h06);
    count_rises(512);
    chk("msb direct rises", 16'h0001, rises >= 15 && rises <= 17);
    wr(6'h04);
    count_rises(512);
    chk("msb halved rises", 16'h0001, rises >= 7 && rises <= 9);
    summarize();
  end
endmodule
